// ---- logic/mon_dbg_ctrl.sv ----
module mon_dbg_ctrl #(
  parameter bit HAS_EL3 = 1'b1,
  parameter bit HAS_NEW_DEBUG = 1'b1,
  parameter bit OS_LOCK_BLOCKED = 1'b1,
  parameter bit HAS_TRF = 1'b1,
  parameter bit HAS_PMU = 1'b1,
  parameter mon_dbg_pkg::cnt_variant_type CNT_VARIANT = mon_dbg_pkg::CNT_V3P7,
  parameter bit HAS_REALM = 1'b0,
  parameter bit TRACE_FILTER_TRAP_RESET = 1'b0
) (
  // clock and warm reset
  input wire logic clk_in,
  input wire logic rst_in,
  // wishbone slave
  input wire mon_dbg_pkg::wb_req_type wb_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // processor state
  input wire logic nonsecure_state_bit_in,
  input wire logic secure_state_in,
  input wire logic at_el3_in,
  input wire logic secure_noninvasive_debug_allowed_in,
  input wire logic trace_auth_override_in,
  // external debugger
  input wire mon_dbg_pkg::dbg_req_type dbg_in,
  output logic dbg_grant_out,
  output logic dbg_deny_out,
  // trace filter register accesses
  input wire mon_dbg_pkg::tf_req_type tf_in,
  output logic tf_trap_out,
  output logic tf_proceed_out,
  output logic [5:0] tf_ec_out,
  // trace and counters
  output logic secure_trace_allowed_out,
  output logic ext_trace_needs_secure_auth_out,
  output logic event_count_enable_out,
  output logic cycle_count_enable_out
);
  // ----------------------------------------
  // build checks
  // ----------------------------------------
  if (HAS_REALM && !HAS_NEW_DEBUG) begin : g_bad_cfg
    $error("realm support needs the newer debug feature");
  end

  // ----------------------------------------
  // control fields
  // ----------------------------------------
  logic ext_dbg_bkpt_access_disable_reg;
  logic trace_filter_trap_reg;
  logic secure_trace_enable_reg;
  logic secure_counting_enable_reg;
  logic ext_dbg_access_disable_ext_reg;
  logic counting_scope_select_reg;
  logic cycle_counter_prohibit_follow_reg;
  logic wb_hit;
  logic wr_ctrl;
  logic wr_ext;
  logic [31:0] wdat;

  assign wb_hit = wb_in.cyc && wb_in.stb && !wb_ack_out;
  assign wr_ctrl = wb_hit && wb_in.we && wb_in.adr == mon_dbg_pkg::CTRL_OFS;
  assign wr_ext = wb_hit && wb_in.we && wb_in.adr == mon_dbg_pkg::EXT_OFS;
  // unselected byte lanes keep their old value
  assign wdat = {{8{wb_in.sel[3]}}, {8{wb_in.sel[2]}}, {8{wb_in.sel[1]}}, {8{wb_in.sel[0]}}}
    & wb_in.dat;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ext_dbg_bkpt_access_disable_reg <= mon_dbg_pkg::CTRL_RESET[mon_dbg_pkg::EXT_DBG_BKPT_ACCESS_DISABLE_POS];
      secure_trace_enable_reg <= mon_dbg_pkg::CTRL_RESET[mon_dbg_pkg::STE_POS];
      secure_counting_enable_reg <= mon_dbg_pkg::CTRL_RESET[mon_dbg_pkg::SECURE_COUNTING_ENABLE_POS];
    end else if (wr_ctrl && wb_in.sel[2]) begin
      ext_dbg_bkpt_access_disable_reg <= wdat[mon_dbg_pkg::EXT_DBG_BKPT_ACCESS_DISABLE_POS];
      secure_trace_enable_reg <= HAS_TRF && wdat[mon_dbg_pkg::STE_POS];
      secure_counting_enable_reg <= HAS_PMU && wdat[mon_dbg_pkg::SECURE_COUNTING_ENABLE_POS];
    end
  end

  // value after warm reset is unspecified; a fixed build value stands in for it
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      trace_filter_trap_reg <= HAS_TRF && TRACE_FILTER_TRAP_RESET;
    end else if (wr_ctrl && wb_in.sel[2]) begin
      trace_filter_trap_reg <= HAS_TRF && wdat[mon_dbg_pkg::TRACE_FILTER_TRAP_POS];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ext_dbg_access_disable_ext_reg <= mon_dbg_pkg::EXT_RESET[mon_dbg_pkg::EXT_DBG_ACCESS_DISABLE_EXT_POS];
      counting_scope_select_reg <= mon_dbg_pkg::EXT_RESET[mon_dbg_pkg::SCOPE_POS];
      cycle_counter_prohibit_follow_reg <= mon_dbg_pkg::EXT_RESET[mon_dbg_pkg::DP_POS];
    end else if (wr_ext && wb_in.sel[0]) begin
      ext_dbg_access_disable_ext_reg <= HAS_REALM && wdat[mon_dbg_pkg::EXT_DBG_ACCESS_DISABLE_EXT_POS];
      counting_scope_select_reg <= (CNT_VARIANT == mon_dbg_pkg::CNT_V3P7)
        && wdat[mon_dbg_pkg::SCOPE_POS];
      cycle_counter_prohibit_follow_reg <= HAS_PMU && wdat[mon_dbg_pkg::DP_POS];
    end
  end

  // ----------------------------------------
  // effective values
  // ----------------------------------------
  logic force_one;
  logic ext_dbg_bkpt_access_disable_eff;
  logic ste_eff;
  logic secure_counting_enable_eff;

  assign force_one = !HAS_EL3 && !nonsecure_state_bit_in;
  assign ext_dbg_bkpt_access_disable_eff = ext_dbg_bkpt_access_disable_reg || force_one;
  assign ste_eff = HAS_TRF && (secure_trace_enable_reg || force_one);
  assign secure_counting_enable_eff = HAS_PMU && (secure_counting_enable_reg || force_one);

  // ----------------------------------------
  // register read and ack
  // ----------------------------------------
  logic [31:0] rd_data;

  always_comb begin
    rd_data = 32'h0000_0000;
    case (wb_in.adr)
      mon_dbg_pkg::CTRL_OFS: begin
        rd_data[mon_dbg_pkg::EXT_DBG_BKPT_ACCESS_DISABLE_POS] = ext_dbg_bkpt_access_disable_reg;
        rd_data[mon_dbg_pkg::TRACE_FILTER_TRAP_POS] = trace_filter_trap_reg;
        rd_data[mon_dbg_pkg::STE_POS] = secure_trace_enable_reg;
        rd_data[mon_dbg_pkg::SECURE_COUNTING_ENABLE_POS] = secure_counting_enable_reg;
      end
      mon_dbg_pkg::EXT_OFS: begin
        rd_data[mon_dbg_pkg::EXT_DBG_ACCESS_DISABLE_EXT_POS] = ext_dbg_access_disable_ext_reg;
        rd_data[mon_dbg_pkg::SCOPE_POS] = counting_scope_select_reg;
        rd_data[mon_dbg_pkg::DP_POS] = cycle_counter_prohibit_follow_reg;
      end
      mon_dbg_pkg::STAT_OFS: begin
        // effective values, as the rest of the block sees them
        rd_data[mon_dbg_pkg::EXT_DBG_BKPT_ACCESS_DISABLE_POS] = ext_dbg_bkpt_access_disable_eff;
        rd_data[mon_dbg_pkg::STE_POS] = ste_eff;
        rd_data[mon_dbg_pkg::SECURE_COUNTING_ENABLE_POS] = secure_counting_enable_eff;
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  // one wait state; unmapped addresses ack with zero
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= wb_hit;
      wb_dat_out <= (wb_hit && !wb_in.we) ? rd_data : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // external debugger access
  // ----------------------------------------
  logic guarded;
  logic realm_ok;
  logic legacy_ok;
  logic dbg_allow;

  assign guarded = dbg_in.target == mon_dbg_pkg::TGT_BKPT_WP
    || (dbg_in.target == mon_dbg_pkg::TGT_OS_LOCK && (HAS_NEW_DEBUG || OS_LOCK_BLOCKED));

  always_comb begin
    realm_ok = 1'b1;
    case ({ext_dbg_access_disable_ext_reg, ext_dbg_bkpt_access_disable_eff})
      2'b01: realm_ok = dbg_in.sec inside {mon_dbg_pkg::SEC_ROOT, mon_dbg_pkg::SEC_SECURE};
      2'b10: realm_ok = dbg_in.sec inside {mon_dbg_pkg::SEC_ROOT, mon_dbg_pkg::SEC_REALM};
      2'b11: realm_ok = dbg_in.sec == mon_dbg_pkg::SEC_ROOT;
      default: realm_ok = 1'b1;
    endcase
  end

  assign legacy_ok = !ext_dbg_bkpt_access_disable_eff || dbg_in.override;
  assign dbg_allow = !guarded || (HAS_REALM ? realm_ok : legacy_ok);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dbg_grant_out <= 1'b0;
      dbg_deny_out <= 1'b0;
    end else begin
      dbg_grant_out <= dbg_in.req && dbg_allow;
      dbg_deny_out <= dbg_in.req && !dbg_allow;
    end
  end

  // ----------------------------------------
  // trace filter register trap
  // ----------------------------------------
  logic tf_lower_el;

  // only el1 and el2 are trapped; el3 and el0 pass through untouched
  assign tf_lower_el = tf_in.el == 2'h1 || tf_in.el == 2'h2;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tf_trap_out <= 1'b0;
      tf_proceed_out <= 1'b0;
      tf_ec_out <= 6'h00;
    end else begin
      tf_trap_out <= tf_in.req && trace_filter_trap_reg && tf_lower_el
        && !tf_in.higher_exc;
      tf_proceed_out <= tf_in.req && !(trace_filter_trap_reg && tf_lower_el)
        && !tf_in.higher_exc;
      if (tf_in.req && trace_filter_trap_reg && tf_lower_el && !tf_in.higher_exc) begin
        tf_ec_out <= tf_in.is64 ? mon_dbg_pkg::EC_TRAP_64 : mon_dbg_pkg::EC_TRAP_32;
      end
    end
  end

  // ----------------------------------------
  // secure trace and counting
  // ----------------------------------------
  logic cnt_applies;
  logic cnt_prohibit;

  always_comb begin
    case (CNT_VARIANT)
      mon_dbg_pkg::CNT_V3P7: begin
        cnt_applies = counting_scope_select_reg ? at_el3_in : secure_state_in;
      end
      mon_dbg_pkg::CNT_V8P2: begin
        cnt_applies = secure_state_in;
      end
      default: begin
        cnt_applies = secure_state_in && !secure_noninvasive_debug_allowed_in;
      end
    endcase
  end

  assign cnt_prohibit = HAS_PMU && cnt_applies && !secure_counting_enable_eff;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      secure_trace_allowed_out <= 1'b0;
      ext_trace_needs_secure_auth_out <= 1'b1;
      event_count_enable_out <= 1'b0;
      cycle_count_enable_out <= 1'b0;
    end else begin
      secure_trace_allowed_out <= !secure_state_in || ste_eff || trace_auth_override_in;
      ext_trace_needs_secure_auth_out <= !ste_eff;
      event_count_enable_out <= !cnt_prohibit;
      cycle_count_enable_out <= !(cnt_prohibit && cycle_counter_prohibit_follow_reg);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  AST_EXT_DBG_BKPT_ACCESS_DISABLE_BLOCKS: assert property (
    dbg_in.req && !HAS_REALM && dbg_in.target == mon_dbg_pkg::TGT_BKPT_WP && ext_dbg_bkpt_access_disable_eff
    && !dbg_in.override |=> dbg_deny_out && !dbg_grant_out)
    else $error("guarded debugger access not refused");
  AST_EXT_DBG_BKPT_ACCESS_DISABLE_CLEAR_GRANTS: assert property (
    dbg_in.req && !ext_dbg_bkpt_access_disable_reg && nonsecure_state_bit_in
    && !ext_dbg_access_disable_ext_reg |=> dbg_grant_out)
    else $error("debugger access refused with disable clear");
  AST_NO_EL3_FORCE: assert property (
    !HAS_EL3 && !nonsecure_state_bit_in && secure_state_in && HAS_TRF |=> secure_trace_allowed_out
    && !ext_trace_needs_secure_auth_out)
    else $error("forced secure trace enable not seen");
  AST_WARM_RESET_CLEAR: assert property (
    $fell(rst_in) |-> !ext_dbg_bkpt_access_disable_reg && !secure_trace_enable_reg
    && !secure_counting_enable_reg)
    else $error("fields not cleared by warm reset");
  AST_TRAP_CLASS: assert property (
    tf_in.req && trace_filter_trap_reg && tf_lower_el && !tf_in.higher_exc
    |=> tf_trap_out && tf_ec_out == ($past(tf_in.is64) ? 6'h18 : 6'h03))
    else $error("trace filter trap or class wrong");
  AST_TRAP_CLEAR_PASS: assert property (
    tf_in.req && !trace_filter_trap_reg && !tf_in.higher_exc |=> !tf_trap_out ##0 tf_proceed_out)
    else $error("trace filter access trapped with trap clear");
  AST_SECURE_TRACE_BLOCK: assert property (
    secure_state_in && !ste_eff && !trace_auth_override_in |=> !secure_trace_allowed_out)
    else $error("secure trace allowed while disabled");
  AST_CYCLE_FREE: assert property (
    !cycle_counter_prohibit_follow_reg [*2] |-> cycle_count_enable_out)
    else $error("cycle counter stopped without prohibit-follow");
  AST_SECURE_COUNTING_ENABLE_SET_RUNS: assert property (
    secure_counting_enable_eff |=> event_count_enable_out && cycle_count_enable_out)
    else $error("counting stopped with secure counting set");
  AST_SECURE_STOP: assert property (
    HAS_PMU && CNT_VARIANT == mon_dbg_pkg::CNT_V3P7 && !counting_scope_select_reg
    && secure_state_in && !secure_counting_enable_eff |=> !event_count_enable_out)
    else $error("event counting not stopped in secure state");
  AST_ABSENT_READS_ZERO: assert property (
    !HAS_TRF |-> !trace_filter_trap_reg && !secure_trace_enable_reg)
    else $error("absent trace feature field not zero");

  COV_DENY: cover property (dbg_deny_out);
  COV_TRAP_64: cover property (tf_trap_out && tf_ec_out == mon_dbg_pkg::EC_TRAP_64);
  COV_SECURE_STOP: cover property (!event_count_enable_out && !cycle_count_enable_out);
  COV_REG_WRITE: cover property (wr_ctrl ##1 wb_ack_out);
endmodule : mon_dbg_ctrl

// ---- logic/mon_dbg_pkg.sv ----
package mon_dbg_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] EXT_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam int EXT_DBG_BKPT_ACCESS_DISABLE_POS = 20;
  localparam int TRACE_FILTER_TRAP_POS = 19;
  localparam int STE_POS = 18;
  localparam int SECURE_COUNTING_ENABLE_POS = 17;
  localparam int EXT_DBG_ACCESS_DISABLE_EXT_POS = 0;
  localparam int SCOPE_POS = 1;
  localparam int DP_POS = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [2:0] EXT_RESET = 3'h0;
  // ----------------------------------------
  // codes
  // ----------------------------------------
  localparam logic [5:0] EC_TRAP_64 = 6'h18;
  localparam logic [5:0] EC_TRAP_32 = 6'h03;
  typedef enum logic [1:0] {SEC_SECURE, SEC_NONSECURE, SEC_REALM, SEC_ROOT} sec_type;
  typedef enum logic [1:0] {TGT_BKPT_WP, TGT_OS_LOCK, TGT_OTHER} target_type;
  typedef enum logic [1:0] {CNT_BASIC, CNT_V8P2, CNT_V3P7} cnt_variant_type;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_type;
  typedef struct packed {
    logic req;
    target_type target;
    sec_type sec;
    logic override;
  } dbg_req_type;
  typedef struct packed {
    logic req;
    logic [1:0] el;
    logic is64;
    logic higher_exc;
  } tf_req_type;
endpackage : mon_dbg_pkg

// ---- sim/mon_dbg_ctrl_bench.sv ----
module mon_dbg_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in, rst_in, ns_bit, sec_st, at_el3, nid_ok, tr_ovr;
  mon_dbg_pkg::wb_req_type wb_in;
  mon_dbg_pkg::dbg_req_type dbg_req;
  mon_dbg_pkg::tf_req_type tf_in;
  logic [31:0] wb_dat, rd;
  logic wb_ack, grant, deny, trap, proceed, st_ok, st_auth, ev_en, cy_en;
  logic [5:0] ec;
  logic [1:0] ans;
  int err_count, n_checks;
  // ----------------------------------------
  // design and debugger model
  // ----------------------------------------
  mon_dbg_ctrl u_mon_dbg_ctrl (.clk_in(clk_in), .rst_in(rst_in), .wb_in(wb_in),
    .wb_dat_out(wb_dat), .wb_ack_out(wb_ack), .nonsecure_state_bit_in(ns_bit),
    .secure_state_in(sec_st), .at_el3_in(at_el3), .secure_noninvasive_debug_allowed_in(nid_ok),
    .trace_auth_override_in(tr_ovr), .dbg_in(dbg_req), .dbg_grant_out(grant),
    .dbg_deny_out(deny), .tf_in(tf_in), .tf_trap_out(trap), .tf_proceed_out(proceed),
    .tf_ec_out(ec), .secure_trace_allowed_out(st_ok), .ext_trace_needs_secure_auth_out(st_auth),
    .event_count_enable_out(ev_en), .cycle_count_enable_out(cy_en));
  mon_dbg_partner u_mon_dbg_partner (.clk_in(clk_in), .dbg_out(dbg_req), .grant_in(grant),
    .deny_in(deny));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk32
  // classic cycle; ack latency is never assumed, only bounded
  task automatic wb_acc(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int i;
    @(posedge clk_in);
    wb_in <= '{cyc:1'b1, stb:1'b1, we:we, adr:adr, sel:4'hf, dat:dat};
    for (i = 0; i < 20; i++) begin
      @(posedge clk_in);
      if (wb_ack === 1'b1) break;
    end
    if (i == 20) begin
      err_count++;
      $display("mismatch at %0t: no ack", $time);
      end_sim();
    end
    rd = wb_dat;
    wb_in <= '0;
  endtask : wb_acc
  task automatic tf_acc(input logic [1:0] el, input logic is64, input logic hx,
                        input logic [1:0] exp);
    @(posedge clk_in);
    tf_in <= '{req:1'b1, el:el, is64:is64, higher_exc:hx};
    @(posedge clk_in);
    tf_in.req <= 1'b0;
    @(posedge clk_in);
    chk32({30'h0, trap, proceed}, {30'h0, exp});
  endtask : tf_acc
  // levels follow their causes one edge later
  task automatic lvl(input logic [1:0] exp);
    repeat (2) @(posedge clk_in);
    chk32({30'h0, ev_en, cy_en}, {30'h0, exp});
  endtask : lvl
  // ----------------------------------------
  // clock and sequence
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial begin
    err_count = 0;
    n_checks = 0;
    rst_in = 1'b1;
    wb_in = '0;
    tf_in = '0;
    ns_bit = 1'b1;
    sec_st = 1'b0;
    at_el3 = 1'b0;
    nid_ok = 1'b0;
    tr_ovr = 1'b0;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    wb_acc(1'b0, 8'h00, 32'h0000_0000);
    chk32(rd & 32'h0016_0000, 32'h0000_0000);
    wb_acc(1'b1, 8'h04, 32'h0000_0007);
    wb_acc(1'b0, 8'h04, 32'h0000_0000);
    chk32(rd, 32'h0000_0006);
    wb_acc(1'b1, 8'h04, 32'h0000_0000);
    u_mon_dbg_partner.access(mon_dbg_pkg::TGT_BKPT_WP, mon_dbg_pkg::SEC_NONSECURE, 1'b0, ans);
    chk32({30'h0, ans}, 32'h0000_0002);
    u_mon_dbg_partner.access(mon_dbg_pkg::TGT_OS_LOCK, mon_dbg_pkg::SEC_SECURE, 1'b0, ans);
    chk32({30'h0, ans}, 32'h0000_0002);
    wb_acc(1'b1, 8'h00, 32'h0010_0000);
    u_mon_dbg_partner.access(mon_dbg_pkg::TGT_BKPT_WP, mon_dbg_pkg::SEC_NONSECURE, 1'b0, ans);
    chk32({30'h0, ans}, 32'h0000_0001);
    u_mon_dbg_partner.access(mon_dbg_pkg::TGT_BKPT_WP, mon_dbg_pkg::SEC_SECURE, 1'b1, ans);
    chk32({30'h0, ans}, 32'h0000_0002);
    u_mon_dbg_partner.access(mon_dbg_pkg::TGT_OS_LOCK, mon_dbg_pkg::SEC_SECURE, 1'b0, ans);
    chk32({30'h0, ans}, 32'h0000_0001);
    u_mon_dbg_partner.access(mon_dbg_pkg::TGT_OTHER, mon_dbg_pkg::SEC_SECURE, 1'b0, ans);
    chk32({30'h0, ans}, 32'h0000_0002);
    wb_acc(1'b1, 8'h00, 32'h0008_0000);
    tf_acc(2'h1, 1'b1, 1'b0, 2'h2);
    chk32({26'h0, ec}, 32'h0000_0018);
    tf_acc(2'h2, 1'b0, 1'b0, 2'h2);
    chk32({26'h0, ec}, 32'h0000_0003);
    tf_acc(2'h0, 1'b1, 1'b0, 2'h1);
    tf_acc(2'h1, 1'b1, 1'b1, 2'h0);
    chk32({26'h0, ec}, 32'h0000_0003);
    wb_acc(1'b1, 8'h00, 32'h0000_0000);
    tf_acc(2'h2, 1'b1, 1'b0, 2'h1);
    sec_st <= 1'b1;
    repeat (2) @(posedge clk_in);
    chk32({30'h0, st_ok, st_auth}, 32'h0000_0001);
    tr_ovr <= 1'b1;
    repeat (2) @(posedge clk_in);
    chk32({31'h0, st_ok}, 32'h0000_0001);
    tr_ovr <= 1'b0;
    wb_acc(1'b1, 8'h00, 32'h0004_0000);
    repeat (2) @(posedge clk_in);
    chk32({30'h0, st_ok, st_auth}, 32'h0000_0002);
    wb_acc(1'b1, 8'h00, 32'h0000_0000);
    sec_st <= 1'b1;
    wb_acc(1'b1, 8'h04, 32'h0000_0004);
    lvl(2'h0);
    wb_acc(1'b1, 8'h04, 32'h0000_0000);
    lvl(2'h1);
    sec_st <= 1'b0;
    lvl(2'h3);
    sec_st <= 1'b1;
    wb_acc(1'b1, 8'h00, 32'h0002_0000);
    lvl(2'h3);
    wb_acc(1'b1, 8'h00, 32'h0000_0000);
    wb_acc(1'b1, 8'h04, 32'h0000_0006);
    lvl(2'h3);
    at_el3 <= 1'b1;
    lvl(2'h0);
    wb_acc(1'b1, 8'h00, 32'h0016_0000);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    wb_acc(1'b0, 8'h00, 32'h0000_0000);
    chk32(rd & 32'h0016_0000, 32'h0000_0000);
    end_sim();
  end
endmodule : mon_dbg_ctrl_bench

// ---- sim/mon_dbg_partner.sv ----
module mon_dbg_partner (
  // clock
  input wire logic clk_in,
  // debugger request and answer
  output mon_dbg_pkg::dbg_req_type dbg_out,
  input wire logic grant_in,
  input wire logic deny_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // external debugger model
  // ----------------------------------------
  initial dbg_out = '0;
  // idle fields are scrambled so that a stale qualifier cannot pass for a live one
  task automatic access(input mon_dbg_pkg::target_type tgt, input mon_dbg_pkg::sec_type sec,
                        input logic ovr, output logic [1:0] ans);
    @(posedge clk_in);
    dbg_out <= '{req:1'b1, target:tgt, sec:sec, override:ovr};
    @(posedge clk_in);
    dbg_out <= '{req:1'b0, target:mon_dbg_pkg::TGT_OTHER, sec:mon_dbg_pkg::sec_type'(~sec),
                 override:~ovr};
    @(posedge clk_in);
    ans = {grant_in, deny_in};
  endtask : access
endmodule : mon_dbg_partner
